// ==== lcp_pkg.sv ====
// Shared constants for both ends of the local CPU bus port.
package lcp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int HCLK_MHZ = 40;
  localparam int WR_GAP_HCLK = 6;
  localparam int RD_GAP_HCLK = 4;
  localparam int WR_GAP_CYC = (WR_GAP_HCLK * CLK_MHZ + HCLK_MHZ - 1) / HCLK_MHZ;
  localparam int RD_GAP_CYC = (RD_GAP_HCLK * CLK_MHZ + HCLK_MHZ - 1) / HCLK_MHZ;
  localparam int RESP_WAIT_NS = 10000;
  localparam int RESP_WAIT_CYC = RESP_WAIT_NS * CLK_MHZ / 1000;
  localparam int LBUS_NS = 80;
  localparam int LBUS_CYC = (LBUS_NS * CLK_MHZ + 999) / 1000;
  localparam int BCLK_HALF_CYC = 5;
  localparam int STRB_MIN_CYC = 8;
  localparam int STRAP_SETTLE = 2;
  localparam int AW = 6;
  localparam int DW = 16;
  localparam logic [5:0] MSG_CMD_ADDR = 6'h00;
  localparam logic [5:0] MSG_FIFO_ADDR = 6'h02;
  localparam logic [5:0] MSG_STAT_ADDR = 6'h00;
  localparam int CMD_CNT_LSB = 12;
  localparam int CMD_WAIT_BIT = 11;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_STEP_BIT = 7;
  localparam int CMD_DOWN_BIT = 6;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_SEND = 3'h3;
  localparam logic [2:0] OP_CLEAR = 3'h4;
  localparam int P0_IRQ_BIT = 0;
  localparam int P0_RPC_BIT = 1;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_GO = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_CLR = 4'h7;
  localparam logic [3:0] REG_IRQ_EN = 4'h8;
  localparam int CTRL_WAIT_BIT = 0;
  localparam int CTRL_POLL_BIT = 1;
  localparam int CTRL_TWO_BIT = 2;
  localparam int CTRL_WIDE_BIT = 3;
  localparam int CTRL_EN_BIT = 4;
  localparam int GO_READ_BIT = 0;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
endpackage

// ==== lcp_bus_if.sv ====
// Local bus wires between the device end and the host end.
`timescale 1ns/1ps
interface lcp_bus_if;
  logic h_cs_n;
  logic h_rd_n;
  logic h_wr_n;
  logic h_ctl_oe;
  logic [lcp_pkg::AW-1:0] h_addr;
  logic [lcp_pkg::DW-1:0] h_dq_o;
  logic h_dq_oe;
  logic d_cs_n;
  logic d_rd_n;
  logic d_wr_n;
  logic d_ctl_oe;
  logic [lcp_pkg::AW-1:0] d_addr;
  logic [lcp_pkg::DW-1:0] d_dq_o;
  logic d_dq_oe;
  logic local_wait_request_n;
  logic local_busy_n;
  logic local_bus_clock_out;
  logic local_chip_select_n;
  logic local_read_strobe_n;
  logic local_write_strobe_n;
  logic [lcp_pkg::AW-1:0] local_addr_bus;
  logic [lcp_pkg::DW-1:0] local_data_bus;
  // Undriven strobes and data float to the pull-up level; the address bus floats low.
  assign local_chip_select_n = d_ctl_oe ? d_cs_n : (h_ctl_oe ? h_cs_n : 1'b1);
  assign local_read_strobe_n = d_ctl_oe ? d_rd_n : (h_ctl_oe ? h_rd_n : 1'b1);
  assign local_write_strobe_n = d_ctl_oe ? d_wr_n : (h_ctl_oe ? h_wr_n : 1'b1);
  assign local_addr_bus = d_ctl_oe ? d_addr : (h_ctl_oe ? h_addr : '0);
  assign local_data_bus = d_dq_oe ? d_dq_o : (h_dq_oe ? h_dq_o : 16'hffff);
  modport dev (
    input local_chip_select_n, local_read_strobe_n, local_write_strobe_n,
    input local_addr_bus, local_data_bus,
    output d_cs_n, d_rd_n, d_wr_n, d_ctl_oe, d_addr, d_dq_o, d_dq_oe,
    output local_wait_request_n, local_busy_n, local_bus_clock_out
  );
  modport host (
    input local_wait_request_n, local_busy_n, local_bus_clock_out, local_data_bus,
    output h_cs_n, h_rd_n, h_wr_n, h_ctl_oe, h_addr, h_dq_o, h_dq_oe
  );
endinterface

// ==== lcp_host.sv ====
// Host end: register-driven local processor that accesses the device.
`timescale 1ns/1ps
module lcp_host (
  input logic ref_clk,
  input logic reset_n,
  lcp_bus_if.host bus,
  input logic [3:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq
);
  typedef enum logic [2:0] {HS_IDLE = 3'b001, HS_PRE = 3'b010, HS_STRB = 3'b100} lcp_hst_t;
  lcp_hst_t st_ff;
  logic [15:0] ctrl_ff;
  logic [5:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic [15:0] rd_out_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic is_rd_ff;
  logic [4:0] gap_ff;
  logic [3:0] scnt_ff;
  logic [17:0] s1_ff;
  logic [17:0] s2_ff;
  logic wait_s;
  logic busy_s;
  logic go;
  logic done;
  logic go_ok;
  logic strb;
  logic two;

  assign wait_s = s2_ff[17];
  assign busy_s = s2_ff[16];
  assign two = ctrl_ff[lcp_pkg::CTRL_TWO_BIT];
  assign go = reg_wr && reg_addr == lcp_pkg::REG_GO;
  assign go_ok = go && st_ff == HS_IDLE;
  assign strb = st_ff == HS_STRB;
  assign done = strb && scnt_ff == 4'h0 && (!ctrl_ff[lcp_pkg::CTRL_WAIT_BIT] || wait_s);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= {2'h3, 16'hffff};
      s2_ff <= {2'h3, 16'hffff};
    end else begin
      s1_ff <= {bus.local_wait_request_n, bus.local_busy_n, bus.local_data_bus};
      s2_ff <= s1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= lcp_pkg::CTRL_RST;
      addr_ff <= '0;
      wdata_ff <= '0;
      irq_en_ff <= lcp_pkg::IRQ_EN_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        lcp_pkg::REG_CTRL: ctrl_ff <= reg_wdata;
        lcp_pkg::REG_ADDR: addr_ff <= reg_wdata[5:0];
        lcp_pkg::REG_WDATA: wdata_ff <= reg_wdata;
        lcp_pkg::REG_IRQ_EN: irq_en_ff <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Bit 0 marks a finished access, bit 1 a refused start; a new event beats a clear.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((reg_wr && reg_addr == lcp_pkg::REG_IRQ_CLR) ?
                      reg_wdata[1:0] : 2'h0)) | {go && !go_ok, done};
    end
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_out_ff <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        lcp_pkg::REG_CTRL: rd_out_ff <= ctrl_ff;
        lcp_pkg::REG_ADDR: rd_out_ff <= {10'h000, addr_ff};
        lcp_pkg::REG_WDATA: rd_out_ff <= wdata_ff;
        lcp_pkg::REG_STAT: rd_out_ff <= {13'h0000, busy_s, gap_ff != 5'h00, st_ff != HS_IDLE};
        lcp_pkg::REG_RDATA: rd_out_ff <= rdata_ff;
        lcp_pkg::REG_IRQ_STAT: rd_out_ff <= {14'h0000, irq_stat_ff};
        lcp_pkg::REG_IRQ_EN: rd_out_ff <= {14'h0000, irq_en_ff};
        default: rd_out_ff <= '0;
      endcase
    end else begin
      rd_out_ff <= '0;
    end
  end

  assign reg_rdata = rd_out_ff;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= HS_IDLE;
      is_rd_ff <= 1'b0;
      gap_ff <= '0;
      scnt_ff <= '0;
      rdata_ff <= '0;
    end else begin
      if (gap_ff != 5'h00) begin
        gap_ff <= gap_ff - 5'h01;
      end
      unique case (st_ff)
        HS_IDLE: if (go_ok) begin
          is_rd_ff <= reg_wdata[lcp_pkg::GO_READ_BIT];
          st_ff <= HS_PRE;
        end
        HS_PRE: begin
          // Without the wait line the host polls busy or keeps the gaps.
          if (ctrl_ff[lcp_pkg::CTRL_POLL_BIT] ? busy_s :
              (ctrl_ff[lcp_pkg::CTRL_WAIT_BIT] || gap_ff == 5'h00)) begin
            scnt_ff <= 4'(lcp_pkg::STRB_MIN_CYC);
            st_ff <= HS_STRB;
          end
        end
        HS_STRB: begin
          if (scnt_ff != 4'h0) begin
            scnt_ff <= scnt_ff - 4'h1;
          end
          if (done) begin
            if (is_rd_ff) begin
              rdata_ff <= ctrl_ff[lcp_pkg::CTRL_WIDE_BIT] ? s2_ff[15:0] : {8'h00, s2_ff[7:0]};
            end
            gap_ff <= is_rd_ff ? 5'(lcp_pkg::RD_GAP_CYC) : 5'(lcp_pkg::WR_GAP_CYC);
            st_ff <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign bus.h_ctl_oe = ctrl_ff[lcp_pkg::CTRL_EN_BIT];
  assign bus.h_cs_n = !strb;
  assign bus.h_rd_n = two ? is_rd_ff : !(strb && is_rd_ff);
  assign bus.h_wr_n = two ? !strb : !(strb && !is_rd_ff);
  assign bus.h_addr = addr_ff;
  assign bus.h_dq_o = wdata_ff;
  assign bus.h_dq_oe = ctrl_ff[lcp_pkg::CTRL_EN_BIT] && strb && !is_rd_ff;
endmodule // lcp_host

// ==== lcp_device.sv ====
// Device end: message-mode slave and emulation-mode local bus master.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// What this block does
// - Straps select 8/16-bit bus and type.
// - Mode strap low selects message mode.
// - Address 0 takes commands, 2 takes FIFO.
// - Read at address 0 returns status.
// - Host keeps six slow clocks between writes.
// - Host keeps four slow clocks between reads.
// - Active-low wait request stretches host access.
// - Busy output low while processing access.
// - Waitless host polls busy or keeps gaps.
// - Write first, then echo read command.
// - Read words follow echo in order.
// - Completion sets port-0 bits one and zero.
// - Wait option returns queue same exchange.
// - Send command returns queued transmit words.
// - Clear command drops completion status bits.
// - Controller opens each exchange itself.
// - Wait option answers within bounded time.
module lcp_device #(
  parameter int TXD = 128
) (
  input logic ref_clk,
  input logic reset_n,
  lcp_bus_if.dev bus,
  input logic bus_type_strap_hi,
  input logic bus_type_strap_lo,
  input logic operating_mode_strap,
  input logic rx_valid,
  input logic [15:0] rx_word,
  input logic rx_last,
  output logic rx_ready,
  input logic tx_ready,
  output logic tx_valid,
  output logic [15:0] tx_word,
  output logic tx_last,
  output logic resp_nodata,
  output logic [1:0] port0_status,
  output logic irq,
  output logic msg_cmd_valid,
  output logic msg_fifo_valid,
  output logic [15:0] msg_word,
  input logic [15:0] msg_status
);
  localparam int PW = $clog2(TXD);
  localparam int TW = $clog2(lcp_pkg::RESP_WAIT_CYC + 1);
  typedef enum logic [4:0] {
    ES_CMD = 5'b00001, ES_DATA = 5'b00010, ES_BUS = 5'b00100,
    ES_RESP = 5'b01000, ES_SEND = 5'b10000
  } lcp_est_t;

  if (TXD < 2 || (TXD & (TXD - 1)) != 0) begin : g_chk
    $error("TXD must be a power of two of at least 2");
  end

  logic [27:0] s1_ff;
  logic [27:0] s2_ff;
  logic [1:0] strap_cnt_ff;
  logic ready_ff;
  logic msg_mode_ff;
  logic wide_ff;
  logic two_ff;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [5:0] addr_s;
  logic [15:0] dq_s;
  logic [5:0] addr_m;
  logic acc_act;
  logic acc_rd;
  logic acc_prev_ff;
  logic acc_start;
  logic mbusy_ff;
  logic [4:0] mcnt_ff;
  logic mrd_ff;
  logic [5:0] maddr_ff;
  logic [15:0] mdata_ff;
  logic mdone;
  logic cmd_pulse_ff;
  logic fifo_pulse_ff;
  logic [15:0] mword_ff;
  lcp_est_t st_ff;
  logic [3:0] cnt_ff;
  logic [5:0] eaddr_ff;
  logic [5:0] nxt_eaddr;
  logic step_ff;
  logic down_ff;
  logic is_rd_ff;
  logic wopt_ff;
  logic first_ff;
  logic last_ff;
  logic did_bus_ff;
  logic send_ff;
  logic resp_done_ff;
  logic resp_ff;
  logic [TW-1:0] tim_ff;
  logic [3:0] bcnt_ff;
  logic [15:0] wdata_ff;
  logic take;
  logic [2:0] op;
  logic [15:0] rd_word;
  logic [15:0] mem [TXD];
  logic [PW-1:0] wp_ff;
  logic [PW-1:0] rp_ff;
  logic [PW:0] fn_ff;
  logic push;
  logic pop;
  logic [15:0] push_data;
  logic [1:0] p0_ff;
  logic [2:0] bclk_cnt_ff;
  logic bclk_ff;
  logic strobe;
  logic cs_ff;
  logic rdl_ff;
  logic wrl_ff;
  logic dq_oe_ff;
  logic [15:0] dq_o_ff;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= {3'h7, 25'h0000000};
      s2_ff <= {3'h7, 25'h0000000};
    end else begin
      s1_ff <= {bus.local_chip_select_n, bus.local_read_strobe_n, bus.local_write_strobe_n,
                bus.local_addr_bus, bus.local_data_bus,
                bus_type_strap_hi, bus_type_strap_lo, operating_mode_strap};
      s2_ff <= s1_ff;
    end
  end

  assign cs_n_s = s2_ff[27];
  assign rd_n_s = s2_ff[26];
  assign wr_n_s = s2_ff[25];
  assign addr_s = s2_ff[24:19];
  assign dq_s = s2_ff[18:3];

  // Straps are caught once, after the synchroniser has filled.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_ff <= '0;
      ready_ff <= 1'b0;
      msg_mode_ff <= 1'b0;
      wide_ff <= 1'b0;
      two_ff <= 1'b0;
    end else if (!ready_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == 2'(lcp_pkg::STRAP_SETTLE)) begin
        ready_ff <= 1'b1;
        wide_ff <= !s2_ff[2];
        two_ff <= !s2_ff[1];
        msg_mode_ff <= !s2_ff[0];
      end
    end
  end

  // Type two uses the read line as direction and the write line as strobe.
  assign acc_act = !cs_n_s && (two_ff ? !wr_n_s : (!rd_n_s || !wr_n_s));
  assign acc_rd = two_ff ? rd_n_s : !rd_n_s;
  assign addr_m = wide_ff ? {addr_s[5:1], 1'b0} : addr_s;
  assign acc_start = ready_ff && msg_mode_ff && acc_act && !acc_prev_ff && !mbusy_ff;
  assign mdone = mbusy_ff && mcnt_ff == 5'h01;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_prev_ff <= 1'b0;
      mbusy_ff <= 1'b0;
      mcnt_ff <= '0;
      mrd_ff <= 1'b0;
      maddr_ff <= '0;
      mdata_ff <= '0;
    end else begin
      acc_prev_ff <= acc_act;
      if (acc_start) begin
        mbusy_ff <= 1'b1;
        mcnt_ff <= acc_rd ? 5'(lcp_pkg::RD_GAP_CYC) : 5'(lcp_pkg::WR_GAP_CYC);
        mrd_ff <= acc_rd;
        maddr_ff <= addr_m;
        mdata_ff <= wide_ff ? dq_s : {8'h00, dq_s[7:0]};
      end else if (mdone) begin
        mbusy_ff <= 1'b0;
      end else if (mbusy_ff) begin
        mcnt_ff <= mcnt_ff - 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_pulse_ff <= 1'b0;
      fifo_pulse_ff <= 1'b0;
      mword_ff <= '0;
    end else begin
      cmd_pulse_ff <= mdone && !mrd_ff && maddr_ff == lcp_pkg::MSG_CMD_ADDR;
      fifo_pulse_ff <= mdone && !mrd_ff && maddr_ff == lcp_pkg::MSG_FIFO_ADDR;
      if (mdone && !mrd_ff) begin
        mword_ff <= mdata_ff;
      end
    end
  end

  assign take = rx_valid && rx_ready;
  assign op = rx_word[lcp_pkg::CMD_OP_LSB +: 3];
  assign rd_word = wide_ff ? dq_s : {8'h00, dq_s[7:0]};
  assign rx_ready = ready_ff && !msg_mode_ff && (st_ff == ES_CMD || st_ff == ES_DATA);

  always_comb begin
    nxt_eaddr = eaddr_ff;
    if (step_ff) begin
      nxt_eaddr = down_ff ? eaddr_ff - (wide_ff ? 6'h02 : 6'h01)
                          : eaddr_ff + (wide_ff ? 6'h02 : 6'h01);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ES_CMD;
      cnt_ff <= '0;
      eaddr_ff <= '0;
      step_ff <= 1'b0;
      down_ff <= 1'b0;
      is_rd_ff <= 1'b0;
      wopt_ff <= 1'b0;
      first_ff <= 1'b1;
      last_ff <= 1'b0;
      did_bus_ff <= 1'b0;
      send_ff <= 1'b0;
      resp_done_ff <= 1'b0;
      resp_ff <= 1'b0;
      tim_ff <= '0;
      bcnt_ff <= '0;
      wdata_ff <= '0;
    end else begin
      resp_ff <= 1'b0;
      if (wopt_ff && !resp_done_ff && !(st_ff == ES_CMD && first_ff)) begin
        if (tim_ff == TW'(lcp_pkg::RESP_WAIT_CYC)) begin
          resp_ff <= 1'b1;
          resp_done_ff <= 1'b1;
        end else begin
          tim_ff <= tim_ff + 1'b1;
        end
      end
      unique case (st_ff)
        ES_CMD: if (take) begin
          first_ff <= rx_last;
          last_ff <= rx_last;
          if (first_ff) begin
            wopt_ff <= rx_word[lcp_pkg::CMD_WAIT_BIT];
            tim_ff <= '0;
            resp_done_ff <= 1'b0;
            did_bus_ff <= 1'b0;
          end
          cnt_ff <= rx_word[lcp_pkg::CMD_CNT_LSB +: 4];
          eaddr_ff <= rx_word[5:0];
          step_ff <= rx_word[lcp_pkg::CMD_STEP_BIT];
          down_ff <= rx_word[lcp_pkg::CMD_DOWN_BIT];
          case (op)
            lcp_pkg::OP_WRITE: begin
              is_rd_ff <= 1'b0;
              st_ff <= ES_DATA;
            end
            lcp_pkg::OP_READ: begin
              is_rd_ff <= 1'b1;
              bcnt_ff <= 4'(lcp_pkg::LBUS_CYC);
              st_ff <= ES_BUS;
            end
            lcp_pkg::OP_SEND: begin
              send_ff <= 1'b1;
              if (rx_last) begin
                st_ff <= ES_RESP;
              end
            end
            default: if (rx_last) begin
              st_ff <= ES_RESP;
            end
          endcase
        end
        ES_DATA: if (take) begin
          wdata_ff <= rx_word;
          first_ff <= rx_last;
          last_ff <= rx_last;
          bcnt_ff <= 4'(lcp_pkg::LBUS_CYC);
          st_ff <= ES_BUS;
        end
        ES_BUS: begin
          if (bcnt_ff == 4'h1) begin
            did_bus_ff <= 1'b1;
            if (cnt_ff == 4'h0) begin
              st_ff <= last_ff ? ES_RESP : ES_CMD;
            end else begin
              cnt_ff <= cnt_ff - 4'h1;
              eaddr_ff <= nxt_eaddr;
              bcnt_ff <= 4'(lcp_pkg::LBUS_CYC);
              st_ff <= is_rd_ff ? ES_BUS : ES_DATA;
            end
          end else begin
            bcnt_ff <= bcnt_ff - 4'h1;
          end
        end
        ES_RESP: begin
          send_ff <= 1'b0;
          resp_done_ff <= 1'b1;
          if (send_ff || (wopt_ff && !resp_done_ff && fn_ff != '0)) begin
            st_ff <= ES_SEND;
          end else begin
            resp_ff <= !resp_done_ff;
            st_ff <= ES_CMD;
          end
        end
        ES_SEND: if (fn_ff == '0) begin
          st_ff <= ES_CMD;
        end
      endcase
    end
  end

  // The read command is echoed first, then each word read in order.
  assign push = (st_ff == ES_CMD && take && op == lcp_pkg::OP_READ) ||
                (st_ff == ES_BUS && is_rd_ff && bcnt_ff == 4'h1);
  assign push_data = st_ff == ES_CMD ? rx_word : rd_word;
  assign pop = st_ff == ES_SEND && tx_ready && fn_ff != '0;

  // A push into a full queue is dropped.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      fn_ff <= '0;
    end else begin
      if (push && fn_ff != (PW+1)'(TXD)) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      fn_ff <= fn_ff + (PW+1)'(push && fn_ff != (PW+1)'(TXD)) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && fn_ff != (PW+1)'(TXD)) begin
      mem[wp_ff] <= push_data;
    end
  end

  assign tx_valid = st_ff == ES_SEND && fn_ff != '0;
  assign tx_word = mem[rp_ff];
  assign tx_last = tx_valid && fn_ff == (PW+1)'(1);
  assign resp_nodata = resp_ff;

  // A completion in the same cycle as a clear command wins.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      p0_ff <= '0;
    end else if (st_ff == ES_RESP && did_bus_ff) begin
      p0_ff[lcp_pkg::P0_RPC_BIT] <= 1'b1;
      p0_ff[lcp_pkg::P0_IRQ_BIT] <= 1'b1;
    end else if (st_ff == ES_CMD && take && op == lcp_pkg::OP_CLEAR) begin
      p0_ff <= '0;
    end
  end

  assign port0_status = p0_ff;
  assign irq = p0_ff[lcp_pkg::P0_IRQ_BIT];
  assign msg_cmd_valid = cmd_pulse_ff;
  assign msg_fifo_valid = fifo_pulse_ff;
  assign msg_word = mword_ff;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_cnt_ff <= '0;
      bclk_ff <= 1'b0;
    end else if (bclk_cnt_ff == 3'(lcp_pkg::BCLK_HALF_CYC - 1)) begin
      bclk_cnt_ff <= '0;
      bclk_ff <= !bclk_ff;
    end else begin
      bclk_cnt_ff <= bclk_cnt_ff + 3'h1;
    end
  end

  // The last two cycles of each bus cycle are idle so that strobes separate.
  assign strobe = st_ff == ES_BUS && bcnt_ff > 4'h2;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_ff <= 1'b1;
      rdl_ff <= 1'b1;
      wrl_ff <= 1'b1;
      dq_oe_ff <= 1'b0;
      dq_o_ff <= '0;
    end else if (msg_mode_ff) begin
      cs_ff <= 1'b1;
      rdl_ff <= 1'b1;
      wrl_ff <= 1'b1;
      dq_oe_ff <= acc_act && acc_rd && addr_m == lcp_pkg::MSG_STAT_ADDR;
      dq_o_ff <= msg_status;
    end else begin
      cs_ff <= !strobe;
      rdl_ff <= two_ff ? !(st_ff == ES_BUS && !is_rd_ff) : !(strobe && is_rd_ff);
      wrl_ff <= two_ff ? !strobe : !(strobe && !is_rd_ff);
      dq_oe_ff <= ready_ff && st_ff == ES_BUS && !is_rd_ff;
      dq_o_ff <= wide_ff ? wdata_ff : {8'h00, wdata_ff[7:0]};
    end
  end

  assign bus.d_ctl_oe = ready_ff && !msg_mode_ff;
  assign bus.d_cs_n = cs_ff;
  assign bus.d_rd_n = rdl_ff;
  assign bus.d_wr_n = wrl_ff;
  assign bus.d_addr = eaddr_ff;
  assign bus.d_dq_o = dq_o_ff;
  assign bus.d_dq_oe = dq_oe_ff;
  assign bus.local_wait_request_n = !mbusy_ff;
  assign bus.local_busy_n = !(mbusy_ff || !(st_ff == ES_CMD && first_ff));
  assign bus.local_bus_clock_out = bclk_ff;
endmodule // lcp_device

// ==== lcp_props.sv ====
// Checker on the local bus wires between both ends.
`timescale 1ns/1ps
module lcp_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic local_wait_request_n,
  input wire logic local_busy_n,
  input wire logic local_chip_select_n,
  input wire logic local_read_strobe_n,
  input wire logic local_write_strobe_n,
  input wire logic d_ctl_oe,
  input wire logic h_ctl_oe,
  input wire logic d_dq_oe,
  input wire logic h_wr_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_one_driver: assert property (!(d_ctl_oe && h_ctl_oe))
    else $error("two control drivers");
  a_wait_in_busy: assert property (!local_wait_request_n |-> !local_busy_n)
    else $error("wait without busy");
  a_wait_cause: assert property ($fell(local_wait_request_n) |->
    $past(local_chip_select_n, 2) == 1'h0) else $error("wait without select");
  a_wait_hold: assert property ($fell(local_wait_request_n) |->
    !local_wait_request_n [*8]) else $error("wait too short");
  a_wait_release: assert property ($fell(local_wait_request_n) |->
    ##[9:16] local_wait_request_n) else $error("wait never released");
  a_read_drive: assert property ($rose(d_dq_oe) && !d_ctl_oe |->
    $past(local_read_strobe_n, 2) == 1'h0) else $error("data driven unasked");
  a_emu_wr_data: assert property (d_ctl_oe && !local_write_strobe_n |-> d_dq_oe)
    else $error("write without data");
  a_host_strobe: assert property ($fell(h_wr_n) && h_ctl_oe |-> !h_wr_n [*8])
    else $error("host strobe short");
endmodule // lcp_props

// ==== local_cpu_bus_port_tb.sv ====
// Bench joining host and device ends across the local bus.
`timescale 1ns/1ps
module local_cpu_bus_port_tb;
  logic ref_clk, reset_n, s_hi, s_lo, s_md, rx_valid, rx_last, rx_ready, tx_ready;
  logic tx_valid, tx_last, nod, irq, dirq, mcv, mfv, reg_wr, reg_rd;
  logic [15:0] rx_word, tx_word, mw, msg_status, reg_wdata, reg_rdata, mc, mf, wa, wd, v, ra;
  logic [1:0] p0;
  logic [3:0] reg_addr;
  logic [15:0] txq[$];
  int n_errors, compares, nd;
  lcp_bus_if lb ();
  lcp_device lcp_device_inst (.ref_clk(ref_clk), .reset_n(reset_n), .bus(lb),
    .bus_type_strap_hi(s_hi), .bus_type_strap_lo(s_lo), .operating_mode_strap(s_md),
    .rx_valid(rx_valid), .rx_word(rx_word), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_word(tx_word), .tx_last(tx_last),
    .resp_nodata(nod), .port0_status(p0), .irq(dirq), .msg_cmd_valid(mcv),
    .msg_fifo_valid(mfv), .msg_word(mw), .msg_status(msg_status));
  lcp_host lcp_host_inst (.ref_clk(ref_clk), .reset_n(reset_n), .bus(lb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  lcp_props lcp_props_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .local_wait_request_n(lb.local_wait_request_n), .local_busy_n(lb.local_busy_n),
    .local_chip_select_n(lb.local_chip_select_n), .local_read_strobe_n(lb.local_read_strobe_n),
    .local_write_strobe_n(lb.local_write_strobe_n), .d_ctl_oe(lb.d_ctl_oe),
    .h_ctl_oe(lb.h_ctl_oe), .d_dq_oe(lb.d_dq_oe), .h_wr_n(lb.h_wr_n));
  always @(posedge ref_clk) begin
    if (mcv) mc <= mw;
    if (mfv) mf <= mw;
    if (lb.d_ctl_oe && !lb.local_read_strobe_n) ra <= {10'h0, lb.local_addr_bus};
    if (lb.d_ctl_oe && !lb.local_write_strobe_n) begin
      wa <= {10'h0, lb.local_addr_bus};
      wd <= lb.local_data_bus;
    end
    if (tx_valid && tx_ready) txq.push_back(tx_word);
    if (nod || (tx_valid && tx_ready && tx_last)) nd++;
  end
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo();
    n_errors++;
    final_report();
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g, input string nm);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  // Host access, then wait until the device has dropped busy.
  task automatic acc(input logic [5:0] a, input logic [15:0] d, input logic r);
    wr(lcp_pkg::REG_ADDR, {10'h0, a});
    wr(lcp_pkg::REG_WDATA, d);
    wr(lcp_pkg::REG_GO, {15'h0, r});
    v = 16'h1;
    for (int i = 0; i < 200 && v[0] !== 1'h0; i++) rd(lcp_pkg::REG_STAT);
    for (int i = 0; i < 200 && lb.local_busy_n !== 1'h1; i++) @(posedge ref_clk);
    if (v[0] !== 1'h0 || lb.local_busy_n !== 1'h1) tmo();
    @(posedge ref_clk);
  endtask
  task automatic tx1(input logic [15:0] w, input logic l);
    @(posedge ref_clk);
    rx_valid <= 1'h1;
    rx_word <= w;
    rx_last <= l;
    v = 16'h0;
    for (int i = 0; i < 3000 && v[0] !== 1'h1; i++) begin
      @(posedge ref_clk);
      v[0] = rx_ready;
    end
    if (v[0] !== 1'h1) tmo();
    rx_valid <= 1'h0;
  endtask
  task automatic wdone(input int k);
    for (int i = 0; i < 3000 && nd < k; i++) @(posedge ref_clk);
    if (nd < k) tmo();
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic boot(input logic h, input logic l, input logic m);
    reset_n <= 1'h0;
    s_hi <= h;
    s_lo <= l;
    s_md <= m;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic msg_writes();
    wr(lcp_pkg::REG_CTRL, 16'h0010);
    wr(lcp_pkg::REG_IRQ_EN, 16'h0001);
    acc(lcp_pkg::MSG_FIFO_ADDR, 16'h00a5, 1'h0);
    chk(16'h00a5, mf, "fifo word");
    chk(16'h0001, {15'h0, irq}, "host irq");
    wr(lcp_pkg::REG_CTRL, 16'h0012);
    acc(lcp_pkg::MSG_CMD_ADDR, 16'h003c, 1'h0);
    chk(16'h003c, mc, "command word");
    wr(lcp_pkg::REG_IRQ_CLR, 16'h0001);
    rd(lcp_pkg::REG_IRQ_STAT);
    chk(16'h0000, {15'h0, irq}, "irq cleared");
  endtask
  task automatic msg_read();
    wr(lcp_pkg::REG_CTRL, 16'h0011);
    acc(lcp_pkg::MSG_STAT_ADDR, 16'h0000, 1'h1);
    rd(lcp_pkg::REG_RDATA);
    chk(16'h005a, {8'h0, v[7:0]}, "status read");
  endtask
  task automatic emu_write_read();
    tx1(16'h0100, 1'h0);
    tx1(16'h1234, 1'h0);
    tx1(16'h1284, 1'h1);
    wdone(1);
    chk(16'h0000, wa, "write addr");
    chk(16'h1234, wd, "write data");
    chk(16'h0003, {14'h0, p0}, "port0");
    chk(16'h0001, {15'h0, dirq}, "dev irq");
    chk(16'h0006, ra, "last read addr");
    chk(16'h0000, 16'(txq.size()), "early words");
    tx1(16'h0300, 1'h1);
    wdone(2);
    chk(16'h1284, txq[0], "echo");
    chk(16'hffff, txq[1], "read one");
    chk(16'hffff, txq[2], "read two");
    chk(16'h0003, {14'h0, p0}, "port0 held");
    tx1(16'h0400, 1'h1);
    wdone(3);
    chk(16'h0000, {15'h0, p0[1]}, "done bit");
  endtask
  task automatic emu_wait();
    tx1(16'h0a84, 1'h1);
    wdone(4);
    chk(16'h0a84, txq[3], "wait echo");
    chk(16'hffff, txq[4], "wait data");
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    rx_valid <= 1'h0;
    rx_last <= 1'h0;
    rx_word <= 16'h0;
    tx_ready <= 1'h1;
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    reg_addr <= 4'h0;
    reg_wdata <= 16'h0;
    msg_status <= 16'h005a;
    boot(1'h1, 1'h1, 1'h0);
    msg_writes();
    msg_read();
    boot(1'h0, 1'h1, 1'h1);
    emu_write_read();
    emu_wait();
    final_report();
  end
endmodule // local_cpu_bus_port_tb
